// ### feos_bus_cycle.v
// one write or read cycle on the flash parallel pins
`timescale 1ns/10ps
`default_nettype none
`include "feos_defines.vh"
module feos_bus_cycle
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        start_i,
    input  wire        write_i,
    input  wire [19:0] addr_i,
    input  wire [7:0]  wdata_i,
    input  wire [7:0]  data_i,
    output reg         done_o,
    output reg  [7:0]  rdata_o,
    output reg  [19:0] addr_o,
    output reg  [7:0]  data_o,
    output reg         data_oe_o,
    output reg         ce_n_o,
    output reg         oe_n_o,
    output reg         we_n_o
);
    localparam S_IDLE    = 4'h1;
    localparam S_SETUP   = 4'h2;
    localparam S_STROBE  = 4'h4;
    localparam S_RECOVER = 4'h8;

    reg [3:0] state;
    reg [7:0] cnt;
    reg       is_write;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state     <= S_IDLE;
            cnt       <= 8'h00;
            is_write  <= 1'b0;
            done_o    <= 1'b0;
            rdata_o   <= 8'h00;
            addr_o    <= 20'h00000;
            data_o    <= 8'h00;
            data_oe_o <= 1'b0;
            ce_n_o    <= 1'b1;
            oe_n_o    <= 1'b1;
            we_n_o    <= 1'b1;
        end
        else
        begin
            done_o <= 1'b0;
            case (state)
            S_IDLE:
                if (start_i)
                begin
                    addr_o   <= addr_i;
                    data_o   <= wdata_i;
                    is_write <= write_i;
                    ce_n_o   <= 1'b0;
                    state    <= S_SETUP;
                end
            S_SETUP:
            begin
                we_n_o    <= ~is_write;
                data_oe_o <= is_write;
                oe_n_o    <= is_write;
                cnt       <= 8'h00;
                state     <= S_STROBE;
            end
            S_STROBE:
            begin
                cnt <= cnt + 8'h01;
                if ((is_write && cnt == `FEOS_WE_LOW_CYC - 1) ||
                    (!is_write && cnt == `FEOS_ACCESS_CYC - 1))
                begin
                    we_n_o <= 1'b1;
                    oe_n_o <= 1'b1;
                    if (!is_write)
                        rdata_o <= data_i;
                    cnt   <= 8'h00;
                    state <= S_RECOVER;
                end
            end
            S_RECOVER:
            begin
                ce_n_o    <= 1'b1;
                data_oe_o <= 1'b0;
                cnt       <= cnt + 8'h01;
                if (cnt == `FEOS_WE_HIGH_CYC - 1)
                begin
                    done_o <= 1'b1;
                    state  <= S_IDLE;
                end
            end
            default:
                state <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### feos_defines.vh
// constants for the flash embedded-operation host controller
`ifndef FEOS_DEFINES_VH
`define FEOS_DEFINES_VH

`define FEOS_CLK_NS          10
`define FEOS_T_WE_LOW_NS     65
`define FEOS_T_WE_HIGH_NS    35
`define FEOS_T_ACCESS_NS     120
`define FEOS_T_RESET_LOW_NS  500
`define FEOS_T_RESET_HIGH_NS 50
`define FEOS_T_BUSY_NS       90
`define FEOS_WE_LOW_CYC   ((`FEOS_T_WE_LOW_NS + `FEOS_CLK_NS - 1) / `FEOS_CLK_NS)
`define FEOS_WE_HIGH_CYC  ((`FEOS_T_WE_HIGH_NS + `FEOS_CLK_NS - 1) / `FEOS_CLK_NS)
`define FEOS_ACCESS_CYC   ((`FEOS_T_ACCESS_NS + `FEOS_CLK_NS - 1) / `FEOS_CLK_NS)
`define FEOS_RST_LOW_CYC  ((`FEOS_T_RESET_LOW_NS + `FEOS_CLK_NS - 1) / `FEOS_CLK_NS)
`define FEOS_RST_HIGH_CYC ((`FEOS_T_RESET_HIGH_NS + `FEOS_CLK_NS - 1) / `FEOS_CLK_NS)
`define FEOS_BUSY_CYC     ((`FEOS_T_BUSY_NS + `FEOS_CLK_NS - 1) / `FEOS_CLK_NS)

`define FEOS_REG_CTRL      8'h00
`define FEOS_REG_STATUS    8'h04
`define FEOS_REG_POLL_ADDR 8'h08
`define FEOS_REG_SEQ_BASE  8'h20
`define FEOS_REG_SEQ_END   8'h50

`define FEOS_CTRL_COUNT_LSB  0
`define FEOS_CTRL_OP_LSB     4
`define FEOS_CTRL_METHOD_LSB 6
`define FEOS_CTRL_RESET      8
`define FEOS_CTRL_START      31

`define FEOS_OP_READ   2'h0
`define FEOS_OP_PROG   2'h1
`define FEOS_OP_SERASE 2'h2
`define FEOS_OP_CERASE 2'h3

`define FEOS_PM_DATA   2'h0
`define FEOS_PM_TOGGLE 2'h1
`define FEOS_PM_PIN    2'h2

`define FEOS_ERASE_CYCLES 3'h6
`define FEOS_MAX_CYCLES   3'h6
`define FEOS_BIT_POLL     7
`define FEOS_BIT_TOGGLE   6
`define FEOS_BIT_TLIMIT   5
`define FEOS_ERASED_BIT   1'b1
`define FEOS_PROTECTED    8'h01

`endif

// ### feos_flash_host.v
// flash host controller: register port, command sequencer, polling
`timescale 1ns/10ps
`default_nettype none
`include "feos_defines.vh"
// Overview of operation
// - after time-limit flag, reread data-poll bit
// - poll at byte, sector or any address
// - after time-limit flag, reread toggle bit
// - erases take six write cycles, then start
module feos_flash_host
(
    input  wire        REF_CLK_I,
    input  wire        SYS_RST_I,
    input  wire [7:0]  AVS_ADDRESS_I,
    input  wire        AVS_READ_I,
    input  wire        AVS_WRITE_I,
    input  wire [31:0] AVS_WRITEDATA_I,
    output reg  [31:0] AVS_READDATA_O,
    output wire        AVS_WAITREQUEST_O,
    output wire [19:0] FLASH_ADDR_O,
    input  wire [7:0]  FLASH_DATA_I,
    output wire [7:0]  FLASH_DATA_O,
    output wire        FLASH_DATA_OE_O,
    output wire        FLASH_CE_N_O,
    output wire        FLASH_OE_N_O,
    output wire        FLASH_WE_N_O,
    output wire        FLASH_RESET_N_O,
    input  wire        FLASH_READY_I
);
    localparam S_IDLE      = 9'h001;
    localparam S_RST_LOW   = 9'h002;
    localparam S_RST_HIGH  = 9'h004;
    localparam S_WRITE     = 9'h008;
    localparam S_WAIT_BUSY = 9'h010;
    localparam S_PIN_WAIT  = 9'h020;
    localparam S_POLL_A    = 9'h040;
    localparam S_POLL_B    = 9'h080;
    localparam S_EVAL      = 9'h100;

    reg [2:0]  ctrl_count;
    reg [1:0]  ctrl_op;
    reg [1:0]  ctrl_method;
    reg [19:0] poll_address;
    reg [19:0] program_target_address [0:5];
    reg [7:0]  program_target_data [0:5];
    reg        ack;
    reg [8:0]  state;
    reg [7:0]  cnt;
    reg [2:0]  idx;
    reg        cyc_go;
    reg        cyc_wait;
    reg        recheck;
    reg        final_read;
    reg [7:0]  rd_first;
    reg [7:0]  rd_second;
    reg [7:0]  last_data;
    reg        reset_n;
    reg        flag_done;
    reg        flag_fail;
    reg        flag_refused;
    reg        flag_recheck;
    reg [31:0] next_readdata;

    wire       cyc_done;
    wire [7:0] cyc_rdata;
    wire       complete;
    wire       time_limit_flag_bit;
    wire [2:0] last_idx = ctrl_count - 3'h1;
    wire       expect_bit;
    wire       idle = (state == S_IDLE);

    function feos_seq_hit;
        input [7:0] a;
        begin
            feos_seq_hit = (a >= `FEOS_REG_SEQ_BASE) &&
                           (a < `FEOS_REG_SEQ_END);
        end
    endfunction

    function [2:0] feos_seq_index;
        input [7:0] a;
        reg   [7:0] off;
        begin
            off = a - `FEOS_REG_SEQ_BASE;
            feos_seq_index = off[5:3];
        end
    endfunction

    // avalon slave: one wait cycle, then answer
    wire       req      = AVS_READ_I | AVS_WRITE_I;
    wire       wr_take  = AVS_WRITE_I & ack;
    wire       ctrl_wr  = wr_take && (AVS_ADDRESS_I == `FEOS_REG_CTRL);
    wire [2:0] new_count = AVS_WRITEDATA_I[`FEOS_CTRL_COUNT_LSB +: 3];
    wire [1:0] new_op    = AVS_WRITEDATA_I[`FEOS_CTRL_OP_LSB +: 2];
    wire [1:0] new_meth  = AVS_WRITEDATA_I[`FEOS_CTRL_METHOD_LSB +: 2];
    wire       want_rst  = AVS_WRITEDATA_I[`FEOS_CTRL_RESET];
    wire       want_go   = AVS_WRITEDATA_I[`FEOS_CTRL_START];
    wire       bad_seq   = (new_op == `FEOS_OP_SERASE ||
                            new_op == `FEOS_OP_CERASE) ?
                           (new_count != `FEOS_ERASE_CYCLES) :
                           (new_op != `FEOS_OP_READ &&
                            (new_count == 3'h0 ||
                             new_count > `FEOS_MAX_CYCLES));
    wire       cmd_reset = ctrl_wr && idle && want_rst;
    wire       cmd_start = ctrl_wr && idle && !want_rst && want_go &&
                           !bad_seq;
    wire       cmd_bad   = ctrl_wr && (want_rst || want_go) &&
                           (!idle || (!want_rst && bad_seq));

    assign AVS_WAITREQUEST_O = req & ~ack;

    always @*
    begin
        next_readdata = 32'h00000000;
        if (AVS_ADDRESS_I == `FEOS_REG_CTRL)
        begin
            next_readdata[`FEOS_CTRL_COUNT_LSB +: 3]  = ctrl_count;
            next_readdata[`FEOS_CTRL_OP_LSB +: 2]     = ctrl_op;
            next_readdata[`FEOS_CTRL_METHOD_LSB +: 2] = ctrl_method;
        end
        else if (AVS_ADDRESS_I == `FEOS_REG_STATUS)
        begin
            next_readdata[0]    = ~idle;
            next_readdata[1]    = flag_done;
            next_readdata[2]    = flag_fail;
            next_readdata[3]    = flag_refused;
            next_readdata[4]    = FLASH_READY_I;
            next_readdata[5]    = flag_recheck;
            next_readdata[15:8] = last_data;
            next_readdata[16]   = (last_data == `FEOS_PROTECTED);
        end
        else if (AVS_ADDRESS_I == `FEOS_REG_POLL_ADDR)
            next_readdata[19:0] = poll_address;
        else if (feos_seq_hit(AVS_ADDRESS_I))
        begin
            if (AVS_ADDRESS_I[2])
                next_readdata[7:0] =
                    program_target_data[feos_seq_index(AVS_ADDRESS_I)];
            else
                next_readdata[19:0] =
                    program_target_address[feos_seq_index(AVS_ADDRESS_I)];
        end
    end

    always @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            ack            <= 1'b0;
            AVS_READDATA_O <= 32'h00000000;
            ctrl_count     <= 3'h0;
            ctrl_op        <= `FEOS_OP_READ;
            ctrl_method    <= `FEOS_PM_DATA;
            poll_address   <= 20'h00000;
        end
        else
        begin
            ack <= req & ~ack;
            if (req & ~ack)
                AVS_READDATA_O <= next_readdata;
            if (cmd_start)
            begin
                ctrl_count  <= new_count;
                ctrl_op     <= new_op;
                ctrl_method <= new_meth;
            end
            if (wr_take && idle &&
                AVS_ADDRESS_I == `FEOS_REG_POLL_ADDR)
                poll_address <= AVS_WRITEDATA_I[19:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1)
        begin : g_seq
            always @(posedge REF_CLK_I)
            begin
                if (SYS_RST_I)
                begin
                    program_target_address[gi] <= 20'h00000;
                    program_target_data[gi]    <= 8'h00;
                end
                else if (wr_take && idle &&
                         feos_seq_hit(AVS_ADDRESS_I) &&
                         feos_seq_index(AVS_ADDRESS_I) == gi)
                begin
                    if (AVS_ADDRESS_I[2])
                        program_target_data[gi] <= AVS_WRITEDATA_I[7:0];
                    else
                        program_target_address[gi] <=
                            AVS_WRITEDATA_I[19:0];
                end
            end
        end
    endgenerate

    // program expects true bit 7 of data; erase expects erased bit
    assign expect_bit = (ctrl_op == `FEOS_OP_PROG) ?
                        program_target_data[last_idx][`FEOS_BIT_POLL] :
                        `FEOS_ERASED_BIT;
    assign FLASH_RESET_N_O = reset_n;

    feos_bus_cycle u_cycle
    (
        .clk_i     (REF_CLK_I),
        .rst_i     (SYS_RST_I),
        .start_i   (cyc_go),
        .write_i   (state == S_WRITE),
        .addr_i    ((state == S_WRITE) ? program_target_address[idx] :
                    poll_address),
        .wdata_i   (program_target_data[idx]),
        .data_i    (FLASH_DATA_I),
        .done_o    (cyc_done),
        .rdata_o   (cyc_rdata),
        .addr_o    (FLASH_ADDR_O),
        .data_o    (FLASH_DATA_O),
        .data_oe_o (FLASH_DATA_OE_O),
        .ce_n_o    (FLASH_CE_N_O),
        .oe_n_o    (FLASH_OE_N_O),
        .we_n_o    (FLASH_WE_N_O)
    );

    feos_poll_eval u_eval
    (
        .method_i   (ctrl_method),
        .expect_i   (expect_bit),
        .first_i    (rd_first),
        .second_i   (rd_second),
        .complete_o (complete),
        .limit_o    (time_limit_flag_bit)
    );

    always @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            state        <= S_RST_LOW;
            cnt          <= 8'h00;
            idx          <= 3'h0;
            cyc_go       <= 1'b0;
            cyc_wait     <= 1'b0;
            recheck      <= 1'b0;
            final_read   <= 1'b0;
            rd_first     <= 8'h00;
            rd_second    <= 8'h00;
            last_data    <= 8'h00;
            reset_n      <= 1'b0;
            flag_done    <= 1'b0;
            flag_fail    <= 1'b0;
            flag_refused <= 1'b0;
            flag_recheck <= 1'b0;
        end
        else
        begin
            cyc_go <= 1'b0;
            if (cyc_done)
                cyc_wait <= 1'b0;
            if (cmd_bad)
                flag_refused <= 1'b1;
            case (state)
            S_IDLE:
                if (cmd_reset)
                begin
                    reset_n <= 1'b0;
                    cnt     <= 8'h00;
                    state   <= S_RST_LOW;
                end
                else if (cmd_start)
                begin
                    flag_done    <= 1'b0;
                    flag_fail    <= 1'b0;
                    flag_refused <= 1'b0;
                    flag_recheck <= 1'b0;
                    recheck      <= 1'b0;
                    idx          <= 3'h0;
                    final_read   <= (new_op == `FEOS_OP_READ);
                    state        <= (new_op == `FEOS_OP_READ) ?
                                    S_POLL_B : S_WRITE;
                    cyc_go       <= 1'b1;
                    cyc_wait     <= 1'b1;
                end
            S_RST_LOW:
            begin
                cnt <= cnt + 8'h01;
                if (cnt == `FEOS_RST_LOW_CYC - 1)
                begin
                    reset_n <= 1'b1;
                    cnt     <= 8'h00;
                    state   <= S_RST_HIGH;
                end
            end
            S_RST_HIGH:
            begin
                cnt <= cnt + 8'h01;
                if (cnt == `FEOS_RST_HIGH_CYC - 1)
                    state <= S_IDLE;
            end
            S_WRITE:
                if (!cyc_wait && !cyc_go)
                begin
                    if (idx == last_idx)
                    begin
                        cnt   <= 8'h00;
                        state <= S_WAIT_BUSY;
                    end
                    else
                    begin
                        idx      <= idx + 3'h1;
                        cyc_go   <= 1'b1;
                        cyc_wait <= 1'b1;
                    end
                end
            S_WAIT_BUSY:
            begin
                // ready/busy and status are not trusted before this
                cnt <= cnt + 8'h01;
                if (cnt == `FEOS_BUSY_CYC - 1)
                begin
                    if (ctrl_method == `FEOS_PM_PIN)
                        state <= S_PIN_WAIT;
                    else
                    begin
                        state    <= (ctrl_method == `FEOS_PM_TOGGLE) ?
                                    S_POLL_A : S_POLL_B;
                        cyc_go   <= 1'b1;
                        cyc_wait <= 1'b1;
                    end
                end
            end
            S_PIN_WAIT:
                if (FLASH_READY_I)
                begin
                    final_read <= 1'b1;
                    state      <= S_POLL_B;
                    cyc_go     <= 1'b1;
                    cyc_wait   <= 1'b1;
                end
            S_POLL_A:
                if (!cyc_wait && !cyc_go)
                begin
                    rd_first <= cyc_rdata;
                    state    <= S_POLL_B;
                    cyc_go   <= 1'b1;
                    cyc_wait <= 1'b1;
                end
            S_POLL_B:
                if (!cyc_wait && !cyc_go)
                begin
                    rd_second <= cyc_rdata;
                    if (final_read)
                    begin
                        last_data <= cyc_rdata;
                        flag_done <= 1'b1;
                        state     <= S_IDLE;
                    end
                    else
                        state <= S_EVAL;
                end
            S_EVAL:
            begin
                last_data <= rd_second;
                if (complete)
                begin
                    flag_done <= 1'b1;
                    state     <= S_IDLE;
                end
                else if (time_limit_flag_bit && recheck)
                begin
                    flag_fail <= 1'b1;
                    flag_done <= 1'b1;
                    reset_n   <= 1'b0;
                    cnt       <= 8'h00;
                    state     <= S_RST_LOW;
                end
                else
                begin
                    if (time_limit_flag_bit)
                    begin
                        recheck      <= 1'b1;
                        flag_recheck <= 1'b1;
                    end
                    state    <= (ctrl_method == `FEOS_PM_TOGGLE) ?
                                S_POLL_A : S_POLL_B;
                    cyc_go   <= 1'b1;
                    cyc_wait <= 1'b1;
                end
            end
            default:
                state <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### feos_flash_host_sva.sv
// assertions on the flash host controller pins
`timescale 1ns/10ps
`default_nettype none
module feos_flash_host_sva
(
    input wire logic        REF_CLK_I,
    input wire logic        SYS_RST_I,
    input wire logic        AVS_READ_I,
    input wire logic        AVS_WRITE_I,
    input wire logic        AVS_WAITREQUEST_O,
    input wire logic [19:0] FLASH_ADDR_O,
    input wire logic [7:0]  FLASH_DATA_O,
    input wire logic        FLASH_DATA_OE_O,
    input wire logic        FLASH_CE_N_O,
    input wire logic        FLASH_OE_N_O,
    input wire logic        FLASH_WE_N_O,
    input wire logic        FLASH_RESET_N_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic [7:0] low_cnt;
    wire        req = AVS_READ_I || AVS_WRITE_I;
    // device reset pulse length; power-up pulse starts high
    always @(posedge REF_CLK_I)
        if (SYS_RST_I)
            low_cnt <= 8'h80;
        else if (FLASH_RESET_N_O)
            low_cnt <= 8'h00;
        else if (low_cnt != 8'hFF)
            low_cnt <= low_cnt + 8'h01;
    AST_WAIT_FIRST: assert property (req && !$past(req) |-> AVS_WAITREQUEST_O)
        else $error("waitrequest low in first request cycle");
    AST_WAIT_ONE: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("request not answered after one cycle");
    AST_WE_LEN: assert property ($fell(FLASH_WE_N_O) |->
        !FLASH_WE_N_O [*7] ##1 FLASH_WE_N_O) else $error("write strobe length");
    AST_OE_LEN: assert property ($fell(FLASH_OE_N_O) |->
        ##11 !FLASH_OE_N_O ##1 FLASH_OE_N_O) else $error("read strobe length");
    AST_WE_FRAME: assert property (!FLASH_WE_N_O |->
        !FLASH_CE_N_O && FLASH_DATA_OE_O && FLASH_OE_N_O) else $error("write frame");
    AST_READ_FREE: assert property (!FLASH_OE_N_O |-> !FLASH_DATA_OE_O && !FLASH_CE_N_O)
        else $error("host drives data during read");
    AST_WR_HOLD: assert property (!FLASH_WE_N_O |->
        $stable(FLASH_DATA_O) && $stable(FLASH_ADDR_O)) else $error("write hold");
    AST_CE_RECOVER: assert property ($rose(FLASH_CE_N_O) |-> FLASH_CE_N_O [*4])
        else $error("chip enable recovery too short");
    AST_POLL_GAP: assert property ($rose(FLASH_WE_N_O) |->
        FLASH_OE_N_O [*8] ##1 FLASH_OE_N_O) else $error("poll too soon");
    AST_RST_LOW: assert property ($rose(FLASH_RESET_N_O) |-> low_cnt >= 8'h32)
        else $error("device reset pulse too short");
endmodule
bind feos_flash_host feos_flash_host_sva u_sva (.REF_CLK_I, .SYS_RST_I,
    .AVS_READ_I, .AVS_WRITE_I, .AVS_WAITREQUEST_O, .FLASH_ADDR_O, .FLASH_DATA_O,
    .FLASH_DATA_OE_O, .FLASH_CE_N_O, .FLASH_OE_N_O, .FLASH_WE_N_O,
    .FLASH_RESET_N_O);
`default_nettype wire

// ### feos_flash_model.sv
// behavioural byte-wide flash device on the far side of the host
`timescale 1ns/10ps
`default_nettype none
module feos_flash_model #(parameter int BUSY_CYC = 200)
(
    input  wire logic        clk_i,
    input  wire logic [19:0] addr_i,
    input  wire logic [7:0]  data_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        reset_n_i,
    input  wire logic        limit_i,
    output logic      [7:0]  data_o,
    output logic             ready_o
);
    logic [7:0] mem [0:15];
    logic [7:0] last = 8'h00, held = 8'h00, cmd3 = 8'h00;
    logic [3:0] paddr = 4'h0;
    logic [2:0] wcnt = 3'h0;
    logic       pwe = 1'b1, poe = 1'b1, busy = 1'b0, tog = 1'b0;
    logic       tflag = 1'b0, erase = 1'b0;
    int         cnt = 0;
    wire  [7:0] stat = {erase ? 1'b0 : ~last[7], tog, tflag, 5'h00};
    assign ready_o = !busy;
    // released bus shows the inverse of its last value
    assign data_o = (ce_n_i || oe_n_i) ? ~held : busy ? stat :
        (cmd3 == 8'h90) ? {7'h00, addr_i[16]} : mem[addr_i[3:0]];
    always @(posedge clk_i)
    begin
        pwe <= we_n_i;
        poe <= oe_n_i;
        if (!ce_n_i && !oe_n_i)
            held <= data_o;
        if (!reset_n_i)
        begin
            busy <= 1'b0;
            wcnt <= 3'h0;
            tflag <= 1'b0;
            cmd3 <= 8'h00;
        end
        else if (busy)
        begin
            cnt <= cnt + 1;
            if (!oe_n_i && poe)
                tog <= ~tog;
            if (erase && cnt == 1)
                for (int i = 0; i < 16; i++) mem[i] <= 8'h00;
            if (cnt == BUSY_CYC && limit_i)
                tflag <= 1'b1;
            else if (cnt == BUSY_CYC)
            begin
                busy <= 1'b0;
                if (erase)
                    for (int i = 0; i < 16; i++) mem[i] <= 8'hFF;
                else
                    mem[paddr] <= last;
            end
        end
        else if (!oe_n_i && poe)
            wcnt <= 3'h0;
        else if (we_n_i && !pwe && !ce_n_i)
        begin
            wcnt <= wcnt + 3'h1;
            last <= data_i;
            paddr <= addr_i[3:0];
            if (wcnt == 3'h2)
                cmd3 <= data_i;
            if (wcnt == 3'h5 || (wcnt == 3'h3 && cmd3 != 8'h80))
            begin
                busy <= 1'b1;
                cnt <= 0;
                erase <= (wcnt == 3'h5);
                wcnt <= 3'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ### feos_poll_eval.v
// judges completion and time-limit from status reads
`timescale 1ns/10ps
`default_nettype none
`include "feos_defines.vh"
module feos_poll_eval
(
    input  wire [1:0] method_i,
    input  wire       expect_i,
    input  wire [7:0] first_i,
    input  wire [7:0] second_i,
    output reg        complete_o,
    output wire       limit_o
);
    assign limit_o = second_i[`FEOS_BIT_TLIMIT];

    always @*
    begin
        if (method_i == `FEOS_PM_TOGGLE)
            complete_o = (first_i[`FEOS_BIT_TOGGLE] ==
                          second_i[`FEOS_BIT_TOGGLE]);
        else
            complete_o = (second_i[`FEOS_BIT_POLL] == expect_i);
    end
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/10ps
`default_nettype none
`include "feos_defines.vh"
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic        lim = 1'b0;
    logic [7:0]  lf = 8'h0F;
    logic [31:0] r;
    logic [19:0] sa [0:5];
    logic [7:0]  sd [0:5];
    wire  [31:0] rdat;
    wire  [19:0] fa;
    wire  [7:0]  fdi, fdo;
    wire         wreq, fdoe, fce, foe, fwe, frs, frdy;
    int          mismatches = 0;
    int          check_count = 0;
    feos_flash_host u_feos_flash_host (.REF_CLK_I(clk), .SYS_RST_I(rst),
        .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
        .FLASH_ADDR_O(fa), .FLASH_DATA_I(fdi), .FLASH_DATA_O(fdo),
        .FLASH_DATA_OE_O(fdoe), .FLASH_CE_N_O(fce), .FLASH_OE_N_O(foe),
        .FLASH_WE_N_O(fwe), .FLASH_RESET_N_O(frs), .FLASH_READY_I(frdy));
    feos_flash_model u_feos_flash_model (.clk_i(clk), .addr_i(fa),
        .data_i(fdo), .ce_n_i(fce), .oe_n_i(foe), .we_n_i(fwe),
        .reset_n_i(frs), .limit_i(lim), .data_o(fdi), .ready_o(frdy));
    initial
        forever #5 clk = ~clk;
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // expected idle status after a clean finish with last data d
    function automatic logic [31:0] st(input logic [7:0] d);
        return {15'h0, d == 8'h01, d, 8'h12};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        @(posedge clk);
        while (wreq !== 1'b0 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        mismatches += int'(n == 20);
        r = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // load n cycles, start op o, poll till idle
    task automatic op(input int n, input logic [1:0] o, input logic [1:0] m,
                      input logic [19:0] pa);
        int k;
        for (k = 0; k < n; k++)
        begin
            bus(1'b1, 8'(8 * k) + 8'h20, {12'h000, sa[k]});
            bus(1'b1, 8'(8 * k) + 8'h24, {24'h0, sd[k]});
        end
        bus(1'b1, `FEOS_REG_POLL_ADDR, {12'h000, pa});
        bus(1'b1, `FEOS_REG_CTRL, {1'b1, 23'h0, m, o, 1'b0, 3'(n)});
        k = 0;
        do
        begin
            bus(1'b0, `FEOS_REG_STATUS, 32'h0);
            k++;
        end
        while (r[0] === 1'b1 && k < 900);
        mismatches += int'(k == 900);
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #400000;
        mismatches++;
        finish_test();
    end
    initial
    begin
        sa = '{20'h00555, 20'h002AA, 20'h00555, 20'h00555, 20'h002AA, 20'h3};
        sd = '{8'hAA, 8'h55, 8'hA0, 8'hAA, 8'h55, 8'h30};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, 8'h10, 32'h0);
        chk(r, 32'h0);
        repeat (60) @(posedge clk);
        op(4, `FEOS_OP_SERASE, `FEOS_PM_DATA, 20'h0);
        chk({31'h0, r[3]}, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            sa[3] = {16'h0, lf[3:0]};
            sd[3] = nxt(lf);
            lf = sd[3];
            op(4, `FEOS_OP_PROG, 2'(i % 3), sa[3]);
            chk(r & 32'h1FF1F, st(sd[3]));
        end
        sd[2] = 8'h80;
        sa[3] = 20'h00555;
        sd[3] = 8'hAA;
        op(6, `FEOS_OP_SERASE, `FEOS_PM_DATA, sa[5]);
        chk(r & 32'h1FF1F, st(8'hFF));
        sd[5] = 8'h10;
        op(6, `FEOS_OP_CERASE, `FEOS_PM_TOGGLE, 20'h00009);
        chk(r & 32'h1FF1F, st(8'hFF));
        sd[2] = 8'h90;
        op(3, `FEOS_OP_PROG, `FEOS_PM_PIN, 20'h10002);
        chk(r & 32'h1FF1F, st(8'h01));
        op(0, `FEOS_OP_READ, `FEOS_PM_DATA, 20'h00002);
        chk(r & 32'h1FF1F, st(8'h00));
        sd[2] = 8'hA0;
        sd[3] = 8'h5A;
        for (int i = 0; i < 2; i++)
        begin
            lim <= 1'b1;
            op(4, `FEOS_OP_PROG, 2'(i), sa[3]);
            chk(r & 32'h26, 32'h26);
            lim <= 1'b0;
            repeat (80) @(posedge clk);
        end
        bus(1'b1, `FEOS_REG_CTRL, 32'h00000100);
        op(4, `FEOS_OP_PROG, `FEOS_PM_DATA, sa[3]);
        chk({31'h0, r[3]}, 32'h1);
        op(4, `FEOS_OP_PROG, `FEOS_PM_DATA, sa[3]);
        chk(r & 32'h1FF1F, st(8'h5A));
        finish_test();
    end
endmodule
`default_nettype wire
